//--- src/sdif_regs.svh
// Functional notes
// [R1] servo enable level enables the motor
// [R2] fault reset acts on rising edge only
// [R3] controller drops enable before fault reset
// [R4] only resettable alarms release operation
// [R5] gain config 1: active P, inactive PI
// [R6] gain config 2: active second gain set
// [R7] switch a selects mode in modes 3-5
// [R8] switch b selects mode in mode 6
// [R9] zero clamp follows its input level
// [R10] command inhibit blocks incoming command pulses
// [R11] overtravel inputs block guarded direction, level-sensitive
// [R12] torque source 1: input selects external limit
// [R13] forward jog runs only while active
// [R14] reverse jog runs only while active
// [R15] gear select picks ratio 1 or 2
// [R16] direction invert flips configured command direction
// [R17] origin both-edge setting forced to low-level
// [R18] homing permitted only while start active
// [R19] terminals synchronised then routed to functions
`ifndef SDIF_REGS_SVH
`define SDIF_REGS_SVH

// terminal and function code widths
`define SDIF_DI_COUNT 8
`define SDIF_FN_W 6
`define SDIF_FN_SLOTS 64

// input function codes
`define SDIF_FN_NONE 6'h00
`define SDIF_FN_SERVO_EN 6'h01
`define SDIF_FN_FAULT_RST 6'h02
`define SDIF_FN_GAIN_SW 6'h03
`define SDIF_FN_MODE_A 6'h0a
`define SDIF_FN_MODE_B 6'h0b
`define SDIF_FN_ZERO_CLAMP_IN 6'h0c
`define SDIF_FN_INHIBIT 6'h0d
`define SDIF_FN_POS_OT 6'h0e
`define SDIF_FN_REV_OT 6'h0f
`define SDIF_FN_FWD_LIM 6'h10
`define SDIF_FN_JOG_FWD 6'h12
`define SDIF_FN_JOG_REV 6'h13
`define SDIF_FN_GEAR_SEL 6'h18
`define SDIF_FN_DIR_INV 6'h1b
`define SDIF_FN_ORIGIN 6'h1f
`define SDIF_FN_HOMING 6'h20

// configuration values
`define SDIF_GAIN_CFG_PPI 2'h1
`define SDIF_GAIN_CFG_SET 2'h2
`define SDIF_TLIM_CFG_EXT 2'h1
`define SDIF_CMODE_W 3
`define SDIF_CMODE_PS 3'h3
`define SDIF_CMODE_PT 3'h4
`define SDIF_CMODE_ST 3'h5
`define SDIF_CMODE_SWB 3'h6
`define SDIF_ORG_LOW 3'h0
`define SDIF_ORG_HIGH 3'h1
`define SDIF_ORG_RISE 3'h2
`define SDIF_ORG_FALL 3'h3
`define SDIF_ORG_BOTH 3'h4

`endif

//--- src/sdif_pkg.sv
package sdif_pkg;
  // active control loop mode
  typedef enum logic [1:0] {
    SDIF_MODE_POS,
    SDIF_MODE_SPD,
    SDIF_MODE_TRQ
  } sdif_mode_t;
endpackage

//--- src/sdif_func_if.sv
`timescale 1ns/1ps
`include "sdif_regs.svh"
// routed function levels between router and core
interface sdif_func_if;
  logic [`SDIF_FN_SLOTS-1:0] func_level;
  modport router (output func_level);
  modport core (input func_level);
endinterface

//--- src/sdif_di_router.sv
`timescale 1ns/1ps
`include "sdif_regs.svh"
module sdif_di_router import sdif_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`SDIF_DI_COUNT-1:0] di_pin,
  input wire logic [`SDIF_DI_COUNT-1:0] di_active_high,
  input wire logic [`SDIF_DI_COUNT-1:0][`SDIF_FN_W-1:0] di_func_sel,
  sdif_func_if.router fout
);
  logic [`SDIF_DI_COUNT-1:0] sync1_reg;
  logic [`SDIF_DI_COUNT-1:0] sync2_reg;
  logic [`SDIF_DI_COUNT-1:0] term_level;
  logic [`SDIF_FN_SLOTS-1:0] func_reg;
  logic [`SDIF_FN_SLOTS-1:0] func_next;
  // marks when sync2 holds a real pin sample after reset
  logic fill1_reg;
  logic fill2_reg;

  // [R19] two-stage terminal sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      fill1_reg <= 1'b0;
      fill2_reg <= 1'b0;
    end else begin
      sync1_reg <= di_pin;
      sync2_reg <= sync1_reg;
      fill1_reg <= 1'b1;
      fill2_reg <= fill1_reg;
    end
  end

  // polarity: active terminal reads as one
  assign term_level = ~(sync2_reg ^ di_active_high);

  // [R19] route terminals to functions
  always_comb begin
    func_next = '0;
    for (int i = 0; i < `SDIF_DI_COUNT; i++) begin
      if (di_func_sel[i] != `SDIF_FN_NONE) begin
        func_next[di_func_sel[i]] = func_next[di_func_sel[i]] | term_level[i];
      end
    end
  end

  // routed levels held in flops; idle until the sync holds a real
  // sample, so a low-active terminal gives no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_reg <= '0;
    end else begin
      func_reg <= fill2_reg ? func_next : '0;
    end
  end

  assign fout.func_level = func_reg;
endmodule

//--- src/sdif_core_top.sv
`timescale 1ns/1ps
`include "sdif_regs.svh"
module sdif_core_top import sdif_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`SDIF_DI_COUNT-1:0] di_pin,
  input wire logic [`SDIF_DI_COUNT-1:0] di_active_high,
  input wire logic [`SDIF_DI_COUNT-1:0][`SDIF_FN_W-1:0] di_func_sel,
  input wire logic [1:0] gain_switch_config,
  input wire logic [1:0] torque_limit_source_config,
  input wire logic [`SDIF_CMODE_W-1:0] composite_mode_cfg,
  input wire logic [2:0] origin_edge_cfg,
  input wire logic cfg_dir_reverse,
  input wire logic alarm_raise,
  input wire logic alarm_resettable,
  input wire logic cmd_pulse_in,
  output logic motor_enable,
  output logic fault_reset_pulse,
  output logic operation_blocked,
  output logic speed_loop_p,
  output logic gain_set_second,
  output sdif_mode_t active_mode,
  output logic zero_clamp_active,
  output logic cmd_pulse_out,
  output logic fwd_motion_allowed,
  output logic rev_motion_allowed,
  output logic fwd_ext_torque_limit,
  output logic jog_fwd_run,
  output logic jog_rev_run,
  output logic gear_ratio_second,
  output logic command_dir_reverse,
  output logic [2:0] origin_edge_eff,
  output logic origin_detect,
  output logic homing_permit
);
  logic rst_s1_reg;
  logic rst_n_int;
  sdif_func_if fif ();

  // picks the first or second mode of a pair
  function automatic sdif_mode_t pair_mode(
    input logic [`SDIF_CMODE_W-1:0] cmode,
    input logic sel
  );
    sdif_mode_t m;
    m = SDIF_MODE_POS;
    case (cmode)
      `SDIF_CMODE_PS: m = sel ? SDIF_MODE_POS : SDIF_MODE_SPD;
      `SDIF_CMODE_PT: m = sel ? SDIF_MODE_TRQ : SDIF_MODE_POS;
      `SDIF_CMODE_ST: m = sel ? SDIF_MODE_TRQ : SDIF_MODE_SPD;
      `SDIF_CMODE_SWB: m = sel ? SDIF_MODE_SPD : SDIF_MODE_POS;
      3'h1: m = SDIF_MODE_SPD;
      3'h2: m = SDIF_MODE_TRQ;
      default: m = SDIF_MODE_POS;
    endcase
    return m;
  endfunction

  // rising edge of a sampled level
  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_int <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_int <= rst_s1_reg;
    end
  end

  sdif_di_router u_router (
    .clk(ref_clk),
    .rst_n(rst_n_int),
    .di_pin(di_pin),
    .di_active_high(di_active_high),
    .di_func_sel(di_func_sel),
    .fout(fif.router)
  );

  // routed function levels
  wire servo_en_lvl = fif.func_level[`SDIF_FN_SERVO_EN];
  wire fault_rst_lvl = fif.func_level[`SDIF_FN_FAULT_RST];
  wire gain_sw_lvl = fif.func_level[`SDIF_FN_GAIN_SW];
  wire mode_switch_a_in = fif.func_level[`SDIF_FN_MODE_A];
  wire mode_switch_b_in = fif.func_level[`SDIF_FN_MODE_B];
  wire zero_clamp_in = fif.func_level[`SDIF_FN_ZERO_CLAMP_IN];
  wire inhibit_lvl = fif.func_level[`SDIF_FN_INHIBIT];
  wire positive_overtravel_in = fif.func_level[`SDIF_FN_POS_OT];
  wire reverse_overtravel_in = fif.func_level[`SDIF_FN_REV_OT];
  wire forward_ext_limit_in = fif.func_level[`SDIF_FN_FWD_LIM];
  wire jog_forward_in = fif.func_level[`SDIF_FN_JOG_FWD];
  wire jog_reverse_in = fif.func_level[`SDIF_FN_JOG_REV];
  wire gear_sel_lvl = fif.func_level[`SDIF_FN_GEAR_SEL];
  wire direction_invert_in = fif.func_level[`SDIF_FN_DIR_INV];
  wire origin_switch_in = fif.func_level[`SDIF_FN_ORIGIN];
  wire homing_start_in = fif.func_level[`SDIF_FN_HOMING];

  // edge history and alarm state
  logic fault_rst_prev_reg;
  logic origin_prev_reg;
  logic alarm_latched_reg;
  logic alarm_hard_reg;

  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      fault_rst_prev_reg <= 1'b0;
      origin_prev_reg <= 1'b0;
    end else begin
      fault_rst_prev_reg <= fault_rst_lvl;
      origin_prev_reg <= origin_switch_in;
    end
  end

  // [R2] edge-triggered fault reset
  wire fault_rst_edge = rise(fault_rst_lvl, fault_rst_prev_reg);
  // [R3] reset honoured only with enable dropped
  wire fault_clear_ok = fault_rst_edge & ~servo_en_lvl;
  // [R4] hard alarms survive a reset
  wire alarm_clear = fault_clear_ok & ~alarm_hard_reg;
  // new alarm wins over a clear in the same cycle
  wire alarm_latched_next = alarm_raise | (alarm_latched_reg & ~alarm_clear);
  wire alarm_hard_next = alarm_raise ? ~alarm_resettable
                                     : (alarm_hard_reg & alarm_latched_next);

  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      alarm_latched_reg <= 1'b0;
      alarm_hard_reg <= 1'b0;
    end else begin
      alarm_latched_reg <= alarm_latched_next;
      alarm_hard_reg <= alarm_hard_next;
    end
  end

  // [R1] enable follows level unless blocked
  wire motor_enable_next = servo_en_lvl & ~alarm_latched_reg;
  // [R5] P or PI speed loop
  wire speed_loop_p_next = (gain_switch_config == `SDIF_GAIN_CFG_PPI)
                           & gain_sw_lvl;
  // [R6] second gain set select
  wire gain_set_second_next = (gain_switch_config == `SDIF_GAIN_CFG_SET)
                              & gain_sw_lvl;
  // [R7] [R8] mode switch by composite mode
  wire mode_uses_b = (composite_mode_cfg == `SDIF_CMODE_SWB);
  wire mode_sel = mode_uses_b ? mode_switch_b_in : mode_switch_a_in;
  sdif_mode_t active_mode_next;
  assign active_mode_next = pair_mode(composite_mode_cfg, mode_sel);
  // [R10] command pulses dropped while inhibited
  wire cmd_pulse_next = cmd_pulse_in & ~inhibit_lvl;
  // [R11] overtravel blocks guarded direction
  wire fwd_allow_next = ~positive_overtravel_in;
  wire rev_allow_next = ~reverse_overtravel_in;
  // [R12] external forward torque limit
  wire fwd_ext_tlim_next =
    (torque_limit_source_config == `SDIF_TLIM_CFG_EXT) & forward_ext_limit_in;
  // [R13] [R14] jog runs while held, not both
  wire jog_fwd_next = jog_forward_in & ~jog_reverse_in & fwd_allow_next;
  wire jog_rev_next = jog_reverse_in & ~jog_forward_in & rev_allow_next;
  // [R16] configured direction flipped
  wire cmd_dir_next = cfg_dir_reverse ^ direction_invert_in;
  // [R17] both-edge setting forced to low level
  wire [2:0] origin_cfg_next = (origin_edge_cfg == `SDIF_ORG_BOTH)
                               ? `SDIF_ORG_LOW : origin_edge_cfg;
  logic origin_detect_next;
  always_comb begin
    unique case (origin_cfg_next)
      `SDIF_ORG_HIGH: origin_detect_next = origin_switch_in;
      `SDIF_ORG_RISE:
        origin_detect_next = rise(origin_switch_in, origin_prev_reg);
      `SDIF_ORG_FALL:
        origin_detect_next = rise(origin_prev_reg, origin_switch_in);
      default: origin_detect_next = ~origin_switch_in;
    endcase
  end

  // level-type outputs
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      motor_enable <= 1'b0;
      speed_loop_p <= 1'b0;
      gain_set_second <= 1'b0;
      active_mode <= SDIF_MODE_POS;
      zero_clamp_active <= 1'b0;
      fwd_motion_allowed <= 1'b0;
      rev_motion_allowed <= 1'b0;
      fwd_ext_torque_limit <= 1'b0;
    end else begin
      motor_enable <= motor_enable_next;
      speed_loop_p <= speed_loop_p_next;
      gain_set_second <= gain_set_second_next;
      active_mode <= active_mode_next;
      // [R9] zero clamp follows input
      zero_clamp_active <= zero_clamp_in;
      fwd_motion_allowed <= fwd_allow_next;
      rev_motion_allowed <= rev_allow_next;
      fwd_ext_torque_limit <= fwd_ext_tlim_next;
    end
  end

  // fault reset, alarm, command, jog, gear, direction, origin and homing outputs
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      fault_reset_pulse <= 1'b0;
      operation_blocked <= 1'b0;
      cmd_pulse_out <= 1'b0;
      jog_fwd_run <= 1'b0;
      jog_rev_run <= 1'b0;
      gear_ratio_second <= 1'b0;
      command_dir_reverse <= 1'b0;
      origin_edge_eff <= `SDIF_ORG_LOW;
      origin_detect <= 1'b0;
      homing_permit <= 1'b0;
    end else begin
      fault_reset_pulse <= fault_clear_ok;
      operation_blocked <= alarm_latched_next;
      cmd_pulse_out <= cmd_pulse_next;
      jog_fwd_run <= jog_fwd_next;
      jog_rev_run <= jog_rev_next;
      // [R15] gear ratio select
      gear_ratio_second <= gear_sel_lvl;
      command_dir_reverse <= cmd_dir_next;
      origin_edge_eff <= origin_cfg_next;
      origin_detect <= origin_detect_next;
      // [R18] homing only while start held
      homing_permit <= homing_start_in;
    end
  end

  // checks on the decoded outputs
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_int);

  servo_off_a: assert property ( // [R1]
    !servo_en_lvl |=> !motor_enable ##1 (motor_enable == $past(
      servo_en_lvl & ~alarm_latched_reg)))
    else $error("motor enabled without servo enable");
  reset_edge_a: assert property ( // [R2]
    fault_reset_pulse |=> !fault_reset_pulse)
    else $error("fault reset acted on a level");
  reset_held_a: assert property ( // [R2]
    fault_rst_lvl [*2] |=> !fault_reset_pulse)
    else $error("fault reset repeated while held");
  hard_alarm_a: assert property ( // [R4]
    alarm_latched_reg && alarm_hard_reg |=> alarm_latched_reg)
    else $error("non-resettable alarm released");
  soft_alarm_a: assert property ( // [R4]
    alarm_latched_reg && !alarm_hard_reg && fault_clear_ok && !alarm_raise
    |=> !alarm_latched_reg ##1 !operation_blocked)
    else $error("resettable alarm not cleared");
  gain_ppi_a: assert property ( // [R5]
    gain_switch_config == `SDIF_GAIN_CFG_PPI && gain_sw_lvl
    |=> speed_loop_p && !gain_set_second)
    else $error("speed loop not in P control");
  gain_set_a: assert property ( // [R6]
    gain_switch_config == `SDIF_GAIN_CFG_SET
    |=> speed_loop_p == 1'b0 && gain_set_second == $past(gain_sw_lvl))
    else $error("wrong gain set selected");
  mode_a_sel_a: assert property ( // [R7]
    composite_mode_cfg == `SDIF_CMODE_PS && $stable(mode_switch_a_in)
    |=> active_mode == ($past(mode_switch_a_in) ? SDIF_MODE_POS
                                                : SDIF_MODE_SPD))
    else $error("mode switch a ignored");
  mode_b_sel_a: assert property ( // [R8]
    composite_mode_cfg == `SDIF_CMODE_SWB && $stable(mode_switch_b_in)
    |=> active_mode == ($past(mode_switch_b_in) ? SDIF_MODE_SPD
                                                : SDIF_MODE_POS))
    else $error("mode switch b ignored");
  inhibit_gate_a: assert property ( // [R10]
    inhibit_lvl |=> !cmd_pulse_out)
    else $error("pulse passed while inhibited");
  overtravel_a: assert property ( // [R11]
    positive_overtravel_in |=> !fwd_motion_allowed && !jog_fwd_run)
    else $error("forward motion past overtravel");
  torque_src_a: assert property ( // [R12]
    torque_limit_source_config != `SDIF_TLIM_CFG_EXT |=> !fwd_ext_torque_limit)
    else $error("external limit used in wrong source");
  jog_stop_a: assert property ( // [R13]
    $fell(jog_forward_in) |=> !jog_fwd_run)
    else $error("forward jog kept running");
  dir_invert_a: assert property ( // [R16]
    1'b1 |=> command_dir_reverse == $past(cfg_dir_reverse ^ direction_invert_in))
    else $error("command direction wrong");
  origin_force_a: assert property ( // [R17]
    origin_edge_cfg == `SDIF_ORG_BOTH |=> origin_edge_eff == `SDIF_ORG_LOW)
    else $error("both-edge origin setting not forced");
  homing_gate_a: assert property ( // [R18]
    !homing_start_in |=> !homing_permit)
    else $error("homing permitted without start");
  homing_on_a: assert property ( // [R18]
    homing_start_in |=> homing_permit)
    else $error("homing refused with start held");
  enable_block_a: assert property ( // [R1]
    alarm_latched_reg |=> !motor_enable)
    else $error("motor enabled with alarm latched");
  reset_gate_a: assert property ( // [R3]
    servo_en_lvl |=> !fault_reset_pulse)
    else $error("fault reset taken with enable on");
  pulse_pass_a: assert property ( // [R10]
    cmd_pulse_in && !inhibit_lvl |=> cmd_pulse_out)
    else $error("pulse lost while not inhibited");
  rev_travel_a: assert property ( // [R11]
    reverse_overtravel_in |=> !rev_motion_allowed && !jog_rev_run)
    else $error("reverse motion past overtravel");
  travel_free_a: assert property ( // [R11]
    !positive_overtravel_in |=> fwd_motion_allowed)
    else $error("forward motion blocked without overtravel");
  torque_ext_a: assert property ( // [R12]
    torque_limit_source_config == `SDIF_TLIM_CFG_EXT && forward_ext_limit_in
    |=> fwd_ext_torque_limit)
    else $error("external limit not applied");
  jog_both_a: assert property ( // [R13]
    jog_forward_in && jog_reverse_in |=> !jog_fwd_run && !jog_rev_run)
    else $error("jog ran with both directions");
  jog_rev_stop_a: assert property ( // [R14]
    $fell(jog_reverse_in) |=> !jog_rev_run)
    else $error("reverse jog kept running");
  zero_clamp_a: assert property ( // [R9]
    zero_clamp_in |=> zero_clamp_active)
    else $error("zero clamp not enabled");
  gear_sel_a: assert property ( // [R15]
    gear_sel_lvl |=> gear_ratio_second)
    else $error("gear ratio two not selected");
  origin_level_a: assert property ( // [R17]
    origin_edge_cfg == `SDIF_ORG_BOTH
    |=> origin_detect == !$past(origin_switch_in))
    else $error("forced origin setting not low level");

  cover_alarm_clear: cover property (
    alarm_latched_reg ##1 fault_clear_ok ##1 !alarm_latched_reg);
  cover_mode_swap: cover property (
    composite_mode_cfg == `SDIF_CMODE_ST && $rose(mode_switch_a_in));
  cover_jog_run: cover property (jog_fwd_run [*3] ##1 !jog_fwd_run);
  cover_origin_rise: cover property (
    origin_edge_eff == `SDIF_ORG_RISE && origin_detect);
  cover_inhibit_drop: cover property (inhibit_lvl && cmd_pulse_in);
endmodule

//--- verif/sdif_ctrl_model.sv
`timescale 1ns/1ps
`include "sdif_regs.svh"
// controller model driving the input terminals
module sdif_ctrl_model (
  input wire logic ref_clk,
  input wire logic [`SDIF_DI_COUNT-1:0] di_active_high,
  input wire logic [`SDIF_DI_COUNT-1:0][`SDIF_FN_W-1:0] di_func_sel,
  output logic [`SDIF_DI_COUNT-1:0] di_pin
);
  logic [`SDIF_FN_SLOTS-1:0] func_req;

  initial func_req = '0;

  // pin level from requested function level and terminal polarity
  always_comb begin
    for (int i = 0; i < `SDIF_DI_COUNT; i++) begin
      di_pin[i] = ~(func_req[di_func_sel[i]] ^ di_active_high[i]);
    end
  end

  // request a function level; caller sits at a falling edge
  task automatic drive(input logic [5:0] code, input logic lvl);
    func_req[code] = lvl;
  endtask

  task automatic clear_fault(input int hold);
    func_req[`SDIF_FN_SERVO_EN] = 1'b0;
    repeat (6) @(negedge ref_clk);
    func_req[`SDIF_FN_FAULT_RST] = 1'b1;
    repeat (hold) @(negedge ref_clk);
    func_req[`SDIF_FN_FAULT_RST] = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
`include "sdif_regs.svh"
module testbench import sdif_pkg::*; ();
  localparam logic [7:0][5:0] MAP_A = {6'h0e, 6'h0d, 6'h0c, 6'h0b,
    6'h0a, 6'h03, 6'h02, 6'h01};
  localparam logic [7:0][5:0] MAP_B = {6'h20, 6'h1f, 6'h1b, 6'h18,
    6'h13, 6'h12, 6'h10, 6'h0f};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] di_pin, di_active_high = 8'h55;
  logic [7:0][5:0] di_func_sel = MAP_A;
  logic [1:0] gain_switch_config = 2'h0, torque_limit_source_config = 2'h0;
  logic [2:0] composite_mode_cfg = 3'h0, origin_edge_cfg = 3'h0;
  logic cfg_dir_reverse = 1'b0, alarm_raise = 1'b0;
  logic alarm_resettable = 1'b0, cmd_pulse_in = 1'b0;
  logic motor_enable, fault_reset_pulse, operation_blocked, speed_loop_p;
  logic gain_set_second, zero_clamp_active, cmd_pulse_out;
  logic fwd_motion_allowed, rev_motion_allowed, fwd_ext_torque_limit;
  logic jog_fwd_run, jog_rev_run, gear_ratio_second, command_dir_reverse;
  logic origin_detect, homing_permit;
  logic [2:0] origin_edge_eff;
  sdif_mode_t active_mode;
  logic [10:0] outs;
  int errors = 0, checks_done = 0, frp_cnt = 0, pout_cnt = 0;

  sdif_ctrl_model ctrl (.ref_clk, .di_active_high, .di_func_sel, .di_pin);

  sdif_core_top uut (.ref_clk, .reset_n, .di_pin, .di_active_high,
    .di_func_sel, .gain_switch_config, .torque_limit_source_config,
    .composite_mode_cfg, .origin_edge_cfg, .cfg_dir_reverse, .alarm_raise,
    .alarm_resettable, .cmd_pulse_in, .motor_enable, .fault_reset_pulse,
    .operation_blocked, .speed_loop_p, .gain_set_second, .active_mode,
    .zero_clamp_active, .cmd_pulse_out, .fwd_motion_allowed,
    .rev_motion_allowed, .fwd_ext_torque_limit, .jog_fwd_run, .jog_rev_run,
    .gear_ratio_second, .command_dir_reverse, .origin_edge_eff,
    .origin_detect, .homing_permit);

  // level outputs gathered for indexed checks
  assign outs = {gain_set_second, speed_loop_p, homing_permit,
    gear_ratio_second, jog_rev_run, jog_fwd_run, fwd_ext_torque_limit,
    rev_motion_allowed, fwd_motion_allowed, zero_clamp_active, motor_enable};

  always #10 ref_clk = ~ref_clk;

  // count one-cycle output pulses
  always @(posedge ref_clk) begin
    if (fault_reset_pulse === 1'b1) frp_cnt++;
    if (cmd_pulse_out === 1'b1) pout_cnt++;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_val(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // pin to output takes four edges; six leaves margin
  task automatic settle;
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic set_lvl(logic [5:0] c, logic v);
    ctrl.drive(c, v);
    settle();
  endtask

  task automatic do_reset;
    ctrl.func_req = '0;
    reset_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    settle();
  endtask

  // drive a function high then low, output k must follow
  task automatic follow(string nm, logic [5:0] c, int k, logic inv);
    for (int v = 1; v >= 0; v--) begin
      set_lvl(c, v[0]);
      chk_bit(nm, v[0] ^ inv, outs[k]);
    end
  endtask

  function automatic logic [1:0] exp_mode(int cm, logic a, logic b);
    logic s;
    s = (cm == 6) ? b : a;
    case (cm)
      3: return s ? SDIF_MODE_POS : SDIF_MODE_SPD;
      4: return s ? SDIF_MODE_TRQ : SDIF_MODE_POS;
      5: return s ? SDIF_MODE_TRQ : SDIF_MODE_SPD;
      default: return s ? SDIF_MODE_SPD : SDIF_MODE_POS;
    endcase
  endfunction

  task automatic pulse_alarm(logic res);
    alarm_resettable = res;
    alarm_raise = 1'b1;
    @(negedge ref_clk);
    alarm_raise = 1'b0;
  endtask

  // alarm latch, refused reset, held reset, non-resettable alarm
  task automatic t_alarm;
    int n;
    pulse_alarm(1'b1);
    chk_bit("operation_blocked", 1'b1, operation_blocked);
    set_lvl(6'h01, 1'b1);
    chk_bit("motor_enable", 1'b0, motor_enable);
    n = frp_cnt;
    set_lvl(6'h02, 1'b1);
    set_lvl(6'h02, 1'b0);
    chk_val("reset pulses", 8'(n), 8'(frp_cnt));
    chk_bit("operation_blocked", 1'b1, operation_blocked);
    n = frp_cnt;
    ctrl.clear_fault(12);
    chk_val("reset pulses", 8'(n + 1), 8'(frp_cnt));
    chk_bit("operation_blocked", 1'b0, operation_blocked);
    pulse_alarm(1'b0);
    ctrl.clear_fault(3);
    chk_bit("operation_blocked", 1'b1, operation_blocked);
    do_reset();
    chk_bit("operation_blocked", 1'b0, operation_blocked);
  endtask

  // composite modes 3 to 6 against both switch inputs
  task automatic t_mode;
    for (int cm = 3; cm <= 6; cm++) begin
      for (int a = 0; a < 2; a++) begin
        for (int b = 0; b < 2; b++) begin
          composite_mode_cfg = 3'(cm);
          ctrl.drive(6'h0a, a[0]);
          set_lvl(6'h0b, b[0]);
          chk_val("active_mode", exp_mode(cm, a[0], b[0]),
            active_mode);
        end
      end
    end
  endtask

  // pulses pass or are dropped by the inhibit level
  task automatic t_inhibit;
    int n;
    for (int v = 0; v < 2; v++) begin
      set_lvl(6'h0d, v[0]);
      n = pout_cnt;
      repeat (3) begin
        cmd_pulse_in = 1'b1;
        @(negedge ref_clk);
        cmd_pulse_in = 1'b0;
        @(negedge ref_clk);
      end
      settle();
      chk_val("cmd pulses", 8'(v ? n : n + 3), 8'(pout_cnt));
    end
    set_lvl(6'h0d, 1'b0);
  endtask

  // second terminal map with flipped polarity
  task automatic t_map_b;
    di_func_sel = MAP_B;
    di_active_high = 8'haa;
    torque_limit_source_config = 2'h1;
    settle();
    follow("rev_motion_allowed", 6'h0f, 3, 1'b1);
    follow("fwd_ext_torque_limit", 6'h10, 4, 1'b0);
    follow("jog_fwd_run", 6'h12, 5, 1'b0);
    follow("jog_rev_run", 6'h13, 6, 1'b0);
    follow("gear_ratio_second", 6'h18, 7, 1'b0);
    follow("homing_permit", 6'h20, 8, 1'b0);
    for (int c = 0; c < 2; c++) begin
      for (int v = 0; v < 2; v++) begin
        cfg_dir_reverse = c[0];
        set_lvl(6'h1b, v[0]);
        chk_bit("command_dir_reverse", c[0] ^ v[0], command_dir_reverse);
      end
    end
    for (int k = 0; k <= 4; k++) begin
      origin_edge_cfg = 3'(k);
      settle();
      chk_val("origin_edge_eff", 8'(k == 4 ? 0 : k), 8'(origin_edge_eff));
      chk_bit("origin_detect", k == 0 || k == 4, origin_detect);
    end
  endtask

  // run guard
  initial begin
    #1000000;
    errors++;
    end_of_test();
  end

  initial begin
    do_reset();
    chk_bit("motor_enable", 1'b0, motor_enable);
    chk_val("active_mode", 8'h00, 8'(active_mode));
    follow("motor_enable", 6'h01, 0, 1'b0);
    t_alarm();
    gain_switch_config = 2'h1;
    follow("speed_loop_p", 6'h03, 9, 1'b0);
    gain_switch_config = 2'h2;
    follow("gain_set_second", 6'h03, 10, 1'b0);
    t_mode();
    follow("zero_clamp_active", 6'h0c, 1, 1'b0);
    t_inhibit();
    follow("fwd_motion_allowed", 6'h0e, 2, 1'b1);
    t_map_b();
    end_of_test();
  end
endmodule
